// ### hdl/vendor_cmd_defs.vh
// constants for the rectifier vendor command handler
`ifndef VENDOR_CMD_DEFS_VH
`define VENDOR_CMD_DEFS_VH
`define CMD_LED_ON 8'hD2
`define CMD_LED_OFF 8'hD3
`define CMD_WR_UNLOCK 8'hD6
`define CMD_WR_LOCK 8'hD7
`define CMD_LATCH_MODE 8'hD8
`define CMD_AUTO_RETRY 8'hD9
`define CMD_ISO_TEST 8'hDA
`define CMD_READ_INPUT 8'hDC
`define CMD_READ_FW 8'hDD
`define CMD_READ_TIMER 8'hDE
`define CMD_FAN_SET 8'hDF
`define CMD_FAN_RELEASE 8'hE0
`define CMD_READ_FAN 8'hE1
`define FAN_FULL_PCT 8'h64
`define VIN_OFFSET_V 8'h4B
`define CLK_HZ 125000000
`define LED_ON_S 7
`define LED_OFF_S 2
`define UNLOCK_MS 10
`define RETRY_DELAY_S 1
`define RETRY_WINDOW_S 60
`define RESTART_OFF_S 2
`define OV_RETRY_MAX 3
`define LV_THRESH_V 36
`define STATUS2_RESTART_OK_BIT 2
`define CNT_LED_ON (`LED_ON_S * `CLK_HZ)
`define CNT_LED_OFF (`LED_OFF_S * `CLK_HZ)
`define CNT_UNLOCK (`UNLOCK_MS * (`CLK_HZ / 1000))
`define CNT_RETRY (`RETRY_DELAY_S * `CLK_HZ)
`define CNT_WINDOW (`RETRY_WINDOW_S * `CLK_HZ)
`define CNT_RESTART_OFF (`RESTART_OFF_S * `CLK_HZ)
`endif

// ### hdl/reply_shifter.v
// reply byte sequencer: count, data bytes low first, then checksum
`timescale 1ns/1ps
module reply_shifter (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  // load side
  input wire load,
  input wire [2:0] count,
  input wire [39:0] data,
  // drain side
  input wire next_byte,
  output reg [7:0] byte_out,
  output reg byte_valid,
  output reg last
);
  reg [2:0] total;
  reg [2:0] idx;
  reg [39:0] shreg;
  reg [7:0] crc;
  wire [7:0] cur = (idx == 3'd0) ? {5'h00, total} : shreg[7:0];
  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer i;
    reg [7:0] r;
    begin
      r = c ^ d;
      for (i = 0; i < 8; i = i + 1) begin
        r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
      end
      crc8 = r;
    end
  endfunction
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      total <= 3'h0;
      idx <= 3'h0;
      shreg <= 40'h0;
      crc <= 8'h00;
      byte_out <= 8'h00;
      byte_valid <= 1'b0;
      last <= 1'b0;
    end else if (clk_en) begin
      if (load) begin
        total <= count;
        idx <= 3'h0;
        shreg <= data;
        crc <= 8'h00;
        byte_valid <= 1'b1;
        byte_out <= {5'h00, count};
        last <= 1'b0;
      end else if (byte_valid && next_byte) begin
        if (last) begin
          byte_valid <= 1'b0;
          last <= 1'b0;
        end else if (idx == total) begin
          // checksum byte closes the reply; count excludes it
          byte_out <= crc8(crc, cur);
          last <= 1'b1;
        end else begin
          crc <= crc8(crc, cur);
          if (idx != 3'd0) begin
            shreg <= {8'h00, shreg[39:8]};
          end
          idx <= idx + 3'd1;
          byte_out <= (idx == 3'd0) ? shreg[7:0] : shreg[15:8];
        end
      end
    end
  end
endmodule // reply_shifter

// ### hdl/vendor_cmd_handler.v
// vendor command handler of the rectifier management interface
//
// Summary of operation
// - LED identify on: both LEDs 7s lit, 2s dark
// - LED identify off: both LEDs dark together while in run state
// - protected memory writes locked until unlock
// - unlock takes effect about 10ms later
// - lock command withdraws protected write permission
// - limit mode above 36V blinks output LED
// - below 36V in limit: no hiccup, unit stays on, output LED lit
// - latch mode holds off after OV, OT, OC
// - latched unit restarts after 2s off event
// - restart clears alarms, sets restart flag
// - auto-retry is default, command restores it
// - OV: two 1s-delayed retries, third OV latches
// - fewer than 3 OV in window resets count
// - isolation failure is information, not fault
// - input readout: voltage minus 75V, power
// - firmware readout: primary, DSP, bus micro bytes
// - run timer hours returned low byte first
// - fan override only raises fan duty
// - fan release returns control to internal logic
// - fan readout: percent plus three speeds, zero absent
// - long replies: count, low byte first, checksum
// - restart flag sits in status-2 bit 2
`timescale 1ns/1ps
`include "vendor_cmd_defs.vh"
module vendor_cmd_handler #(
  parameter CNT_LED_ON = `CNT_LED_ON,
  parameter CNT_LED_OFF = `CNT_LED_OFF,
  parameter CNT_UNLOCK = `CNT_UNLOCK,
  parameter CNT_RETRY = `CNT_RETRY,
  parameter CNT_WINDOW = `CNT_WINDOW,
  parameter CNT_RESTART_OFF = `CNT_RESTART_OFF
) (
  // clock and reset; rst_b models loss of internal bias
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  // decoded command from the bus engine, same clock
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire [7:0] cmd_data,
  // telemetry inputs, same clock
  input wire [7:0] vin_volts,
  input wire [15:0] pin_watts,
  input wire [7:0] vout_volts,
  input wire [7:0] fw_primary,
  input wire [7:0] fw_dsp,
  input wire [7:0] fw_bus,
  input wire [23:0] run_hours,
  input wire [7:0] fan_internal_pct,
  input wire [7:0] fan1_rpm,
  input wire [7:0] fan2_rpm,
  input wire [7:0] fan3_rpm,
  // protection events, same clock
  input wire in_limit,
  input wire ov_trip,
  input wire ot_trip,
  input wire oc_trip,
  input wire restart_ok,
  input wire iso_done,
  input wire iso_pass,
  // off requests: the two pins sampled twice, op_off used directly
  input wire remote_off_pin,
  input wire module_absent_pin,
  input wire op_off,
  // reply bytes
  input wire reply_next,
  output reg [7:0] reply_byte,
  output reg reply_valid,
  output reg reply_last,
  // front panel and power stage
  output reg led_output,
  output reg led_input,
  output reg unit_on,
  output reg latched_off,
  output reg latch_mode,
  output reg protect_wr_en,
  output reg [7:0] fan_duty_pct,
  output reg alarms_clear,
  output reg status2_restart_ok,
  output reg iso_test_start,
  output reg iso_failed_info,
  output reg iso_ok,
  output reg internal_fault,
  output reg led_identify
);
  localparam S_RUN = 4'b0001;
  localparam S_RETRY = 4'b0010;
  localparam S_LATCH = 4'b0100;
  localparam S_OFF = 4'b1000;
  reg [3:0] state;
  reg [31:0] led_cnt, unlock_cnt, win_cnt, dly_cnt, off_cnt;
  reg led_phase, led_quiet, unlock_pend, fan_override, win_open, blink_div, rs_load;
  reg [7:0] fan_host_pct;
  reg [1:0] ov_count;
  reg rem_s1, rem_s2, abs_s1, abs_s2;
  reg [23:0] blink_cnt;
  reg [2:0] rs_count;
  reg [39:0] rs_data;
  wire [7:0] rs_byte;
  wire rs_valid, rs_last;
  wire fast = (vout_volts > `LV_THRESH_V);
  wire off_req = rem_s2 | abs_s2 | op_off;
  wire fault_trip = ov_trip | ot_trip | oc_trip;
  wire restart_evt = (state == S_OFF && !off_req && off_cnt >= CNT_RESTART_OFF) ||
                     (state == S_LATCH && cmd_valid && cmd_code == `CMD_AUTO_RETRY);
  wire [7:0] vin_rel = vin_volts - `VIN_OFFSET_V;
  wire [7:0] fan_eff = (fan_override && fan_host_pct > fan_internal_pct) ?
                       fan_host_pct : fan_internal_pct;
  // second-stage flops only are read downstream
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rem_s1 <= 1'b0;
      rem_s2 <= 1'b0;
      abs_s1 <= 1'b0;
      abs_s2 <= 1'b0;
    end else if (clk_en) begin
      rem_s1 <= remote_off_pin;
      rem_s2 <= rem_s1;
      abs_s1 <= module_absent_pin;
      abs_s2 <= abs_s1;
    end
  end
  // command decoding and reply loading
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      led_identify <= 1'b0;
      led_quiet <= 1'b0;
      latch_mode <= 1'b0;
      unlock_pend <= 1'b0;
      protect_wr_en <= 1'b0;
      fan_override <= 1'b0;
      fan_host_pct <= 8'h00;
      iso_test_start <= 1'b0;
      rs_load <= 1'b0;
      rs_count <= 3'h0;
      rs_data <= 40'h0;
      unlock_cnt <= 32'h0;
    end else if (clk_en) begin
      iso_test_start <= 1'b0;
      rs_load <= 1'b0;
      led_quiet <= (state == S_RUN) && (led_quiet || (cmd_valid && cmd_code == `CMD_LED_OFF));
      if (unlock_pend) begin
        if (unlock_cnt == CNT_UNLOCK - 1) begin
          unlock_pend <= 1'b0;
          protect_wr_en <= 1'b1;
        end else begin
          unlock_cnt <= unlock_cnt + 32'h1;
        end
      end
      if (cmd_valid) begin
        case (cmd_code)
          `CMD_LED_ON: led_identify <= 1'b1;
          `CMD_LED_OFF: led_identify <= 1'b0;
          `CMD_WR_UNLOCK: begin
            unlock_pend <= 1'b1;
            unlock_cnt <= 32'h0;
          end
          `CMD_WR_LOCK: begin
            unlock_pend <= 1'b0;
            protect_wr_en <= 1'b0;
          end
          `CMD_LATCH_MODE: latch_mode <= 1'b1;
          `CMD_AUTO_RETRY: latch_mode <= 1'b0;
          `CMD_ISO_TEST: iso_test_start <= 1'b1;
          `CMD_READ_INPUT: begin
            rs_load <= 1'b1;
            rs_count <= 3'd3;
            rs_data <= {16'h0, pin_watts, vin_rel};
          end
          `CMD_READ_FW: begin
            rs_load <= 1'b1;
            rs_count <= 3'd3;
            rs_data <= {16'h0, fw_bus, fw_dsp, fw_primary};
          end
          `CMD_READ_TIMER: begin
            rs_load <= 1'b1;
            rs_count <= 3'd3;
            rs_data <= {16'h0, run_hours};
          end
          `CMD_FAN_SET: begin
            fan_override <= 1'b1;
            fan_host_pct <= (cmd_data > `FAN_FULL_PCT) ? `FAN_FULL_PCT : cmd_data;
          end
          `CMD_FAN_RELEASE: fan_override <= 1'b0;
          `CMD_READ_FAN: begin
            rs_load <= 1'b1;
            rs_count <= 3'd4;
            // absent fans report zero rpm at their inputs
            rs_data <= {8'h0, fan3_rpm, fan2_rpm, fan1_rpm, fan_eff};
          end
          default: ;
        endcase
      end
    end
  end
  // identify cycle of both front LEDs
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      led_cnt <= 32'h0;
      led_phase <= 1'b0;
    end else if (clk_en) begin
      if (!led_identify) begin
        led_cnt <= 32'h0;
        led_phase <= 1'b1;
      end else if (led_phase && led_cnt == CNT_LED_ON - 1) begin
        led_cnt <= 32'h0;
        led_phase <= 1'b0;
      end else if (!led_phase && led_cnt == CNT_LED_OFF - 1) begin
        led_cnt <= 32'h0;
        led_phase <= 1'b1;
      end else begin
        led_cnt <= led_cnt + 32'h1;
      end
    end
  end
  // output LED blink divider for limit indication
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_cnt <= 24'h0;
      blink_div <= 1'b0;
    end else if (clk_en) begin
      blink_cnt <= blink_cnt + 24'h1;
      if (blink_cnt == 24'hFFFFFF) begin
        blink_div <= ~blink_div;
      end
    end
  end
  // shutdown, retry and latch handling
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_RUN;
      ov_count <= 2'd0;
      win_cnt <= 32'h0;
      win_open <= 1'b0;
      dly_cnt <= 32'h0;
      off_cnt <= 32'h0;
      alarms_clear <= 1'b0;
      status2_restart_ok <= 1'b0;
    end else if (clk_en) begin
      alarms_clear <= 1'b0;
      if (win_open) begin
        if (win_cnt == CNT_WINDOW - 1) begin
          win_open <= 1'b0;
          ov_count <= 2'd0;
        end else begin
          win_cnt <= win_cnt + 32'h1;
        end
      end
      if ((state == S_RUN && restart_ok) || restart_evt) begin
        alarms_clear <= 1'b1;
        status2_restart_ok <= 1'b1;
      end
      case (state)
        S_RUN: begin
          if (off_req) begin
            state <= S_OFF;
          end else if (ov_trip && !latch_mode) begin
            dly_cnt <= 32'h0;
            if (!win_open) begin
              win_open <= 1'b1;
              win_cnt <= 32'h0;
            end
            if (ov_count == `OV_RETRY_MAX - 1) begin
              state <= S_LATCH;
            end else begin
              ov_count <= ov_count + 2'd1;
              state <= S_RETRY;
            end
          end else if (fault_trip && latch_mode) begin
            state <= S_LATCH;
          end else if (fault_trip) begin
            dly_cnt <= 32'h0;
            state <= S_RETRY;
          end
        end
        S_RETRY: begin
          if (dly_cnt == CNT_RETRY - 1) begin
            state <= S_RUN;
          end else begin
            dly_cnt <= dly_cnt + 32'h1;
          end
        end
        S_LATCH: begin
          off_cnt <= 32'h0;
          if (cmd_valid && cmd_code == `CMD_AUTO_RETRY) begin
            state <= S_RUN;
            ov_count <= 2'd0;
          end else if (off_req) begin
            state <= S_OFF;
          end
        end
        S_OFF: begin
          if (off_req) begin
            if (off_cnt != CNT_RESTART_OFF) begin
              off_cnt <= off_cnt + 32'h1;
            end
          end else if (off_cnt >= CNT_RESTART_OFF) begin
            state <= S_RUN;
            ov_count <= 2'd0;
            off_cnt <= 32'h0;
          end else begin
            // too short an off time leaves the unit latched
            state <= S_LATCH;
          end
        end
        default: state <= S_RUN;
      endcase
    end
  end
  // registered outputs
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      led_output <= 1'b0;
      led_input <= 1'b0;
      unit_on <= 1'b0;
      latched_off <= 1'b0;
      fan_duty_pct <= 8'h00;
      iso_failed_info <= 1'b0;
      iso_ok <= 1'b0;
      internal_fault <= 1'b0;
      reply_byte <= 8'h00;
      reply_valid <= 1'b0;
      reply_last <= 1'b0;
    end else if (clk_en) begin
      unit_on <= (state == S_RUN);
      latched_off <= (state == S_LATCH);
      fan_duty_pct <= fan_eff;
      if (led_identify) begin
        led_output <= led_phase;
        led_input <= led_phase;
      end else if (led_quiet) begin
        led_output <= 1'b0;
        led_input <= 1'b0;
      end else if (state == S_RUN && in_limit && fast) begin
        led_output <= blink_div;
        led_input <= 1'b1;
      end else begin
        led_output <= (state == S_RUN);
        led_input <= 1'b1;
      end
      if (iso_done) begin
        iso_ok <= iso_pass;
        iso_failed_info <= ~iso_pass;
      end
      internal_fault <= 1'b0;
      reply_byte <= rs_byte;
      reply_valid <= rs_valid;
      reply_last <= rs_valid & rs_last;
    end
  end
  reply_shifter u_reply (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .load(rs_load),
    .count(rs_count),
    .data(rs_data),
    .next_byte(reply_next),
    .byte_out(rs_byte),
    .byte_valid(rs_valid),
    .last(rs_last)
  );
endmodule // vendor_cmd_handler

// ### tb/vendor_cmd_chk.sv
// port checker for the vendor command handler
`timescale 1ns/1ps
module vendor_cmd_chk #(
  parameter CNT_UNLOCK = 40
) (
  // clock and reset
  input logic ref_clk,
  input logic rst_b,
  // command
  input logic clk_en,
  input logic cmd_valid,
  input logic [7:0] cmd_code,
  // outputs
  input logic [7:0] reply_byte,
  input logic reply_valid,
  input logic led_output,
  input logic led_input,
  input logic led_identify,
  input logic latch_mode,
  input logic protect_wr_en,
  input logic internal_fault
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire tk = clk_en && cmd_valid;
  int since;
  // saturates so a long idle run cannot wrap into the window
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) since <= 0;
    else if (tk && cmd_code == 8'hD6) since <= 1;
    else if (since < 1000000) since <= since + 1;
  end
  property p_led_on;
    tk && cmd_code == 8'hD2 |-> ##1 led_identify ##1 led_output && led_input;
  endproperty
  a_led_on: assert property (p_led_on) else $error("identify not started");
  property p_led_off;
    tk && cmd_code == 8'hD3 |-> ##1 !led_identify ##1 !led_output && !led_input;
  endproperty
  a_led_off: assert property (p_led_off) else $error("leds not off");
  property p_unlock_wait;
    tk && cmd_code == 8'hD6 && !protect_wr_en |-> ##1 !protect_wr_en [*8];
  endproperty
  a_unlock_wait: assert property (p_unlock_wait) else $error("unlock too soon");
  property p_unlock_time;
    $rose(protect_wr_en) |-> since >= CNT_UNLOCK && since <= CNT_UNLOCK + 2;
  endproperty
  a_unlock_time: assert property (p_unlock_time) else $error("unlock delay");
  property p_lock;
    tk && cmd_code == 8'hD7 |-> ##1 !protect_wr_en;
  endproperty
  a_lock: assert property (p_lock) else $error("lock ignored");
  property p_latch;
    tk && cmd_code == 8'hD8 |-> ##1 latch_mode;
  endproperty
  a_latch: assert property (p_latch) else $error("latch mode not set");
  property p_auto;
    tk && cmd_code == 8'hD9 |-> ##1 !latch_mode;
  endproperty
  a_auto: assert property (p_auto) else $error("auto retry not set");
  property p_no_fault;
    !internal_fault;
  endproperty
  a_no_fault: assert property (p_no_fault) else $error("internal fault set");
  property p_reply;
    tk && cmd_code == 8'hDE ##1 !cmd_valid [*2] |-> ##1 reply_valid && reply_byte == 8'h03;
  endproperty
  a_reply: assert property (p_reply) else $error("reply count late");
endmodule // vendor_cmd_chk

bind vendor_cmd_handler vendor_cmd_chk #(.CNT_UNLOCK(CNT_UNLOCK)) chk (.*);

// ### tb/mgmt_host_model.sv
// host controller model: commands, reply draining, remote pin
`timescale 1ns/1ps
module mgmt_host_model (
  // clock
  input logic ref_clk,
  // command and reply
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_data,
  input logic reply_valid,
  output logic reply_next,
  // remote pin
  output logic remote_off_pin
);
  logic lclk;
  initial begin
    {cmd_valid, reply_next, remote_off_pin, lclk} = 4'h0;
    {cmd_code, cmd_data} = 16'h0000;
  end
  // one unit at a time; released lines show the inverse value
  task cmd(input logic [7:0] c, input logic [7:0] d);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_data <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    cmd_data <= ~d;
  endtask
  task drain(input int n);
    int t;
    t = 0;
    while (reply_valid !== 1'b1 && t < 40) begin
      @(posedge ref_clk);
      #1 t++;
    end
    repeat (n) begin
      @(posedge ref_clk);
      reply_next <= 1'b1;
      @(posedge ref_clk);
      reply_next <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  // link clock runs only while the pin is being driven
  task pin_off(input int n);
    #3;
    repeat (n) begin
      lclk = 1'b1;
      remote_off_pin = 1'b1;
      #62.5 lclk = 1'b0;
      #62.5;
    end
    lclk = 1'b1;
    remote_off_pin = 1'b0;
    #62.5 lclk = 1'b0;
  endtask
endmodule // mgmt_host_model

// ### tb/testbench.sv
// self-checking bench for the vendor command handler
`timescale 1ns/1ps
module testbench;
  localparam CNT_UNLOCK = 40;
  localparam CNT_RESTART_OFF = 100;
  logic ref_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, cmd_valid, reply_next, remote_off_pin;
  logic [7:0] cmd_code, cmd_data, vin_volts, vout_volts, fw_primary, fw_dsp, fw_bus, reply_byte;
  logic [7:0] fan_internal_pct, fan1_rpm, fan2_rpm, fan3_rpm, fan_duty_pct;
  logic [15:0] pin_watts;
  logic [23:0] run_hours;
  logic in_limit, ov_trip, ot_trip, oc_trip, restart_ok, iso_done, iso_pass, module_absent_pin;
  logic op_off, reply_valid, reply_last, led_output, led_input, unit_on, latched_off, latch_mode;
  logic protect_wr_en, alarms_clear, status2_restart_ok, iso_test_start, iso_failed_info, iso_ok;
  logic internal_fault, led_identify;
  logic [2:0] trip = 3'h0;
  int n_errors = 0, n_compared = 0, n_clear = 0;
  logic [31:0] seed = 32'h4E97EA49;
  logic [9:0] q[$];
  logic [7:0] fs[3] = '{8'h10, 8'hC8, 8'h40};
  logic [7:0] fe[3] = '{8'h20, 8'h64, 8'h40};
  logic [7:0] rc[4] = '{8'hDC, 8'hDD, 8'hDE, 8'hE1};
  assign {oc_trip, ot_trip, ov_trip} = trip;
  vendor_cmd_handler #(.CNT_LED_ON(60), .CNT_LED_OFF(20), .CNT_UNLOCK(CNT_UNLOCK),
    .CNT_RETRY(30), .CNT_WINDOW(400), .CNT_RESTART_OFF(CNT_RESTART_OFF)) dut (.*);
  mgmt_host_model host (.*);
  always #4 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    repeat (8) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task pulse(input int k);
    @(posedge ref_clk) trip <= 3'h1 << k;
    @(posedge ref_clk) trip <= 3'h0;
  endtask
  task off_hold();
    @(posedge ref_clk) op_off <= 1'b1;
    cyc(CNT_RESTART_OFF + 20);
    @(posedge ref_clk) op_off <= 1'b0;
  endtask
  task iso(input logic p);
    @(posedge ref_clk);
    iso_done <= 1'b1;
    iso_pass <= p;
    @(posedge ref_clk) iso_done <= 1'b0;
    cyc(3);
  endtask
  // random telemetry, then the expected block reply goes on the queue
  task rd(input logic [7:0] c);
    logic [31:0] r, s, d;
    int n;
    logic [7:0] cr;
    r = xs();
    s = xs();
    @(posedge ref_clk);
    vin_volts <= 8'h4B + {1'b0, r[6:0]};
    {pin_watts, vout_volts, fw_primary} <= {r[31:8], r[7:0]};
    {fw_dsp, fw_bus, fan1_rpm, fan2_rpm} <= s;
    fan3_rpm <= r[15:8];
    run_hours <= {s[7:0], r[31:16]};
    cyc(1);
    n = 3;
    case (c)
      8'hDC: d = {8'h00, pin_watts, vin_volts - 8'h4B};
      8'hDD: d = {8'h00, fw_bus, fw_dsp, fw_primary};
      8'hDE: d = {8'h00, run_hours};
      default: begin n = 4; d = {fan3_rpm, fan2_rpm, fan1_rpm, 8'h40}; end
    endcase
    cr = crc8(8'h00, n[7:0]);
    q.push_back({2'b10, n[7:0]});
    for (int i = 0; i < n; i++) begin
      q.push_back({2'b10, d[8*i+:8]});
      cr = crc8(cr, d[8*i+:8]);
    end
    q.push_back({2'b11, cr});
    host.cmd(c, r[7:0]);
    host.drain(n + 2);
  endtask
  always @(posedge ref_clk) begin
    if (alarms_clear === 1'b1) n_clear++;
    if (rst_b && reply_next === 1'b1) begin
      if (q.size() == 0) chk("reply", 24'h0, 24'hFFFFFF);
      else chk("reply", q.pop_front(), {reply_valid, reply_last, reply_byte});
    end
  end
  task final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #(8 * 20000);
    n_errors++;
    final_report();
  end
  initial begin
    {vin_volts, vout_volts, fw_primary, fw_dsp, fw_bus, fan1_rpm, fan2_rpm, fan3_rpm} = '0;
    {pin_watts, run_hours, in_limit, restart_ok, iso_done, iso_pass} = '0;
    {module_absent_pin, op_off} = 2'b00;
    fan_internal_pct = 8'h20;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    cyc(3);
    chk("reset", 6'b111000, {unit_on, led_output, led_input, latch_mode, protect_wr_en,
      internal_fault});
    host.cmd(8'hD2, 8'h00);
    cyc(30);
    chk("lit", 2'b11, {led_output, led_input});
    cyc(40);
    chk("dark", 2'b00, {led_output, led_input});
    cyc(25);
    chk("relit", 2'b11, {led_output, led_input});
    host.cmd(8'hD3, 8'h00);
    cyc(3);
    chk("off", 3'b000, {led_output, led_input, led_identify});
    host.cmd(8'hD6, 8'h00);
    host.cmd(8'hD7, 8'h00);
    cyc(CNT_UNLOCK + 10);
    chk("cancel", 1'b0, protect_wr_en);
    host.cmd(8'hD6, 8'h00);
    cyc(CNT_UNLOCK - 5);
    chk("early", 1'b0, protect_wr_en);
    cyc(10);
    chk("unlock", 1'b1, protect_wr_en);
    host.cmd(8'hD7, 8'h00);
    cyc(2);
    chk("lock", 1'b0, protect_wr_en);
    for (int i = 0; i < 3; i++) begin
      host.cmd(8'hDF, fs[i]);
      cyc(3);
      chk("duty", fe[i], fan_duty_pct);
    end
    for (int i = 0; i < 8; i++) rd(rc[i % 4]);
    host.cmd(8'hE0, 8'h00);
    cyc(3);
    chk("release", 8'h20, fan_duty_pct);
    host.cmd(8'hD8, 8'h00);
    for (int k = 0; k < 3; k++) begin
      pulse(k);
      cyc(5);
      chk("latched", 2'b10, {latched_off, unit_on});
      if (k == 0) off_hold();
      else begin
        host.pin_off(3);
        cyc(20);
        chk("short off", 2'b10, {latched_off, unit_on});
        host.pin_off(12);
      end
      cyc(10);
      chk("restart", 3'b011, {latched_off, unit_on, status2_restart_ok});
    end
    chk("clears", 24'd3, n_clear);
    host.cmd(8'hD9, 8'h00);
    for (int k = 0; k < 3; k++) begin
      pulse(0);
      cyc(20);
      chk("retry wait", 1'b0, unit_on);
      cyc(25);
      chk("retry", (k < 2) ? 2'b01 : 2'b10, {latched_off, unit_on});
    end
    off_hold();
    repeat (2) begin pulse(0); cyc(45); end
    cyc(400);
    repeat (2) begin pulse(0); cyc(45); end
    chk("window", 2'b01, {latched_off, unit_on});
    host.cmd(8'hDA, 8'h00);
    cyc(60);
    iso(1'b0);
    chk("iso fail", 2'b10, {iso_failed_info, internal_fault});
    host.cmd(8'hDA, 8'h00);
    cyc(60);
    iso(1'b1);
    chk("iso ok", 2'b10, {iso_ok, internal_fault});
    host.cmd(8'hD8, 8'h00);
    @(posedge ref_clk) rst_b <= 1'b0;
    cyc(2);
    @(posedge ref_clk) rst_b <= 1'b1;
    cyc(3);
    chk("bias loss", 2'b01, {latch_mode, unit_on});
    final_report();
  end
endmodule // testbench
